// *** pkg/ashp_map.svh ***
// Constants of the converter serial host port
`ifndef ASHP_MAP_SVH
`define ASHP_MAP_SVH

// Clock periods in ns; master clock assumed equal to core clock by default
`define ASHP_CORE_NS 20
`define ASHP_MCLK_NS 20

// Initialisation after reset, in master-clock periods
`define ASHP_INIT_MCLKS 18
`define ASHP_INIT_CYC \
	((`ASHP_INIT_MCLKS * `ASHP_MCLK_NS + `ASHP_CORE_NS - 1) / `ASHP_CORE_NS)

// Modulator period in master-clock periods, per clock-rate select
`define ASHP_MOD_MCLKS_SLOW 4
`define ASHP_MOD_MCLKS_FAST 16
`define ASHP_MOD_CYC_SLOW \
	((`ASHP_MOD_MCLKS_SLOW * `ASHP_MCLK_NS + `ASHP_CORE_NS - 1) / `ASHP_CORE_NS)
`define ASHP_MOD_CYC_FAST \
	((`ASHP_MOD_MCLKS_FAST * `ASHP_MCLK_NS + `ASHP_CORE_NS - 1) / `ASHP_CORE_NS)

// Power-down after this many modulator periods held low
`define ASHP_PD_MODS 512

// Frame layout
`define ASHP_FRAME_BITS 48
`define ASHP_STAT_SYNC 4'hC

// Opcodes decoded on the seventh falling edge (upper seven bits)
`define ASHP_OP7_START 7'h04
`define ASHP_OP7_STOP 7'h05
`define ASHP_OP7_CONT_RD 7'h08
`define ASHP_OP7_SDATAC 7'h09
`define ASHP_OP7_RDATA 7'h0A
// Opcodes decoded on the eighth falling edge
`define ASHP_OP_RESET 8'h06
`define ASHP_OP_REGWR_HI 4'h4

// Register addresses and fields
`define ASHP_ADDR_CFG 4'h1
`define ASHP_ADDR_LEAD 4'h2
`define ASHP_ADDR_PIN 4'h3
`define ASHP_CFG_SINGLE 7
`define ASHP_LEAD_CLKDIV 6
`define ASHP_CFG_RST 8'h02
`define ASHP_PIN_RST 4'hC
`define ASHP_CONT_RST 1'b1

`endif

// *** pkg/ashp_pkg.sv ***
// Types of the converter serial host port
package ashp_pkg;
	typedef enum logic [1:0] {
		st_cmd,
		st_wcount,
		st_wdata,
		st_read
	} ashp_spi_state_e;
endpackage

// *** src/ashp_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ashp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Pins in, synchronised out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meta <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// *** src/ashp_fifo.sv ***
// Small sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ashp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = count != (AW + 1)'(DEPTH);
	assign out_valid = count != '0;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

// *** src/ashp_port.sv ***
// Serial host port of a two-channel 16-bit converter
`timescale 1ns/1ps
`include "ashp_map.svh"
// What this block does
// - Deselect resets interface, floats data-out
// - Data-ready falls on completion, ignoring select
// - Partial commands recovered by deselect
// - Data-in sampled on falling serial edge
// - Data-out shifted on rising edge, MSB first
// - Continuous read and on-demand read supported
// - First falling serial edge raises data-ready
// - Frame: status plus two 16-bit channels
// - Status: 1100, lead bits, pins, zeros
// - Powered-down channel slot sends zeros
// - Extra clocks repeat the frame
// - Overlapping read never corrupts shifted data
// - Two pins: direction, true levels, defaults
// - Reset on either pin edge; long low powers down
// - Reset command at eighth edge, 18 clocks
// - New primary config write resets filter
// - Conversions only after start pin or command
// - Config bit 7 selects single-shot mode
// - System commands decoded on seventh edge, except reset (eighth edge)
// - Start raises data-ready until first result
// - Single-shot stops after one conversion
module ashp_port #(
	parameter int FIFO_DEPTH = 4,
	parameter int PD_MODS = `ASHP_PD_MODS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	output logic data_ready_n,
	// Control pins
	input wire logic start_pin,
	input wire logic powerdown_reset_n,
	// General-purpose pins
	input wire logic [1:0] gpio_in,
	output logic [1:0] gpio_out,
	output logic [1:0] gpio_oe,
	// Samples from the converter core
	input wire logic sample_valid,
	output logic sample_ready,
	input wire logic [31:0] sample_data,
	input wire logic [4:0] lead_off_flags,
	input wire logic [1:0] chan_powerdown,
	// Status and control toward the core
	output logic conv_run,
	output logic filter_reset,
	output logic powered_down,
	output logic continuous_read_mode,
	output logic [1:0] pin_level_bits
);
	localparam logic [4:0] INIT_CYC = 5'(`ASHP_INIT_CYC);
	localparam logic [4:0] MOD_SLOW = 5'(`ASHP_MOD_CYC_SLOW);
	localparam logic [4:0] MOD_FAST = 5'(`ASHP_MOD_CYC_FAST);
	localparam logic [5:0] LAST_BIT = 6'(`ASHP_FRAME_BITS - 1);

	logic cs_s, sclk_s, din_s, start_s, pwdn_s;
	logic [1:0] gpio_s;
	logic sclk_d, start_d, pwdn_d;
	ashp_pkg::ashp_spi_state_e state;
	logic [2:0] bcnt;
	logic [7:0] shreg;
	logic [3:0] waddr;
	logic rd_pend;
	logic [7:0] primary_config_reg;
	logic [7:0] lead_status_reg;
	logic [1:0] pin_direction_bits;
	logic [1:0] pin_out_bits;
	logic [`ASHP_FRAME_BITS-1:0] frame;
	logic [5:0] fcnt;
	logic running;
	logic [4:0] init_cnt;
	logic [4:0] modcnt;
	logic [9:0] pd_cnt;
	logic fifo_valid;
	logic [31:0] fifo_data;
	logic fall, rise, sel, bit_in, byte_end, hit7;
	logic [6:0] op7;
	logic [7:0] opcode;
	logic rst_cmd, start_cmd, stop_cmd, wr, cfg_new;
	logic start_evt, stop_evt, soft_rst, init_busy, accept, load, rd_act, busy;
	logic [4:0] mod_len;
	logic mod_tick;

	ashp_sync #(
		.WIDTH(7),
		.RST_VAL(7'h44)
	) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.async_in({cs_n, sclk, din, start_pin, powerdown_reset_n, gpio_in}),
		.sync_out({cs_s, sclk_s, din_s, start_s, pwdn_s, gpio_s})
	);

	// Holds samples while a frame is being shifted out
	ashp_fifo #(
		.WIDTH(32),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.in_valid(sample_valid & running & ~init_busy),
		.in_ready(sample_ready),
		.in_data(sample_data),
		.out_valid(fifo_valid),
		.out_ready(load),
		.out_data(fifo_data)
	);

	assign fall = ~sclk_s & sclk_d;
	assign rise = sclk_s & ~sclk_d;
	assign sel = ~cs_s;
	assign bit_in = fall & sel;
	assign op7 = {shreg[5:0], din_s};
	assign opcode = {shreg[6:0], din_s};
	assign byte_end = bit_in & (bcnt == 3'd7);
	assign hit7 = bit_in & (state == ashp_pkg::st_cmd) & (bcnt == 3'd6);
	assign start_cmd = hit7 & (op7 == `ASHP_OP7_START);
	assign stop_cmd = hit7 & (op7 == `ASHP_OP7_STOP);
	assign rst_cmd = byte_end & (state == ashp_pkg::st_cmd) & (opcode == `ASHP_OP_RESET);
	assign wr = byte_end & (state == ashp_pkg::st_wdata);
	assign cfg_new = wr & (waddr == `ASHP_ADDR_CFG) & (opcode != primary_config_reg);
	// Start by pin rise or command
	assign start_evt = ~init_busy & ((start_s & ~start_d) | start_cmd);
	assign stop_evt = (~start_s & start_d) | stop_cmd;
	assign soft_rst = (pwdn_d & ~pwdn_s) | (~pwdn_d & pwdn_s) | rst_cmd;
	assign init_busy = (init_cnt != 5'd0) | ~pwdn_s;
	assign accept = sample_valid & sample_ready & running & ~init_busy;
	assign rd_act = sel & (continuous_read_mode | (state == ashp_pkg::st_read));
	assign busy = rd_act & (fcnt != 6'd0);
	assign load = fifo_valid & ~busy & ~init_busy;
	assign mod_len = lead_status_reg[`ASHP_LEAD_CLKDIV] ? MOD_FAST : MOD_SLOW;
	assign mod_tick = modcnt == mod_len - 5'd1;
	assign dout_oe = sel;
	assign conv_run = running;
	assign gpio_oe = ~pin_direction_bits;
	assign gpio_out = pin_out_bits;
	assign pin_level_bits = gpio_s;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sclk_d <= 1'b0;
			start_d <= 1'b0;
			pwdn_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			start_d <= start_s;
			pwdn_d <= pwdn_s;
		end
	end

	// Command shifter; deselect drops any half-sent command
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= ashp_pkg::st_cmd;
			bcnt <= 3'd0;
			shreg <= 8'h00;
			waddr <= 4'h0;
			rd_pend <= 1'b0;
		end else if (!sel) begin
			state <= ashp_pkg::st_cmd;
			bcnt <= 3'd0;
			rd_pend <= 1'b0;
		end else if (bit_in) begin
			shreg <= opcode;
			bcnt <= bcnt + 3'd1;
			if (hit7 && op7 == `ASHP_OP7_RDATA) begin
				rd_pend <= 1'b1;
			end
			if (byte_end) begin
				case (state)
					ashp_pkg::st_cmd: begin
						rd_pend <= 1'b0;
						if (rd_pend) begin
							state <= ashp_pkg::st_read;
						end else if (opcode[7:4] == `ASHP_OP_REGWR_HI) begin
							waddr <= opcode[3:0];
							state <= ashp_pkg::st_wcount;
						end
					end
					ashp_pkg::st_wcount: state <= ashp_pkg::st_wdata;
					ashp_pkg::st_wdata: state <= ashp_pkg::st_cmd;
					ashp_pkg::st_read: state <= ashp_pkg::st_read;
					default: state <= ashp_pkg::st_cmd;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			continuous_read_mode <= `ASHP_CONT_RST;
		end else if (init_busy) begin
			continuous_read_mode <= `ASHP_CONT_RST;
		end else if (hit7 && op7 == `ASHP_OP7_CONT_RD) begin
			continuous_read_mode <= 1'b1;
		end else if (hit7 && op7 == `ASHP_OP7_SDATAC) begin
			continuous_read_mode <= 1'b0;
		end
	end

	// Register file; defaults reloaded throughout initialisation
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			primary_config_reg <= `ASHP_CFG_RST;
			lead_status_reg <= 8'h00;
			{pin_direction_bits, pin_out_bits} <= `ASHP_PIN_RST;
		end else begin
			lead_status_reg[4:0] <= lead_off_flags;
			if (init_busy) begin
				primary_config_reg <= `ASHP_CFG_RST;
				lead_status_reg[`ASHP_LEAD_CLKDIV] <= 1'b0;
				{pin_direction_bits, pin_out_bits} <= `ASHP_PIN_RST;
			end else if (wr) begin
				case (waddr)
					`ASHP_ADDR_CFG: primary_config_reg <= opcode;
					`ASHP_ADDR_LEAD: lead_status_reg[`ASHP_LEAD_CLKDIV] <= opcode[6];
					`ASHP_ADDR_PIN: begin
						pin_direction_bits <= opcode[3:2];
						for (int i = 0; i < 2; i++) begin
							if (!opcode[2 + i]) begin
								pin_out_bits[i] <= opcode[i];
							end
						end
					end
					default: primary_config_reg <= primary_config_reg;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			frame <= '0;
		end else if (load) begin
			// Status, then channel one, then channel two
			frame <= {`ASHP_STAT_SYNC, lead_status_reg[4:0], gpio_s, 5'h00,
				chan_powerdown[0] ? 16'h0000 : fifo_data[31:16],
				chan_powerdown[1] ? 16'h0000 : fifo_data[15:0]};
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fcnt <= 6'd0;
			dout <= 1'b0;
		end else if (!sel) begin
			fcnt <= 6'd0;
			dout <= 1'b0;
		end else if (rise && rd_act) begin
			dout <= frame[LAST_BIT - fcnt];
			fcnt <= (fcnt == LAST_BIT) ? 6'd0 : fcnt + 6'd1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			running <= 1'b0;
		end else if (init_busy) begin
			running <= (init_cnt == 5'd1) & pwdn_s & start_s;
		end else if (start_evt) begin
			running <= 1'b1;
		end else if (stop_evt) begin
			running <= 1'b0;
		end else if (accept && primary_config_reg[`ASHP_CFG_SINGLE]) begin
			running <= 1'b0;
		end
	end

	// Data-ready; completion wins over a same-cycle clear
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			data_ready_n <= 1'b1;
		end else if (load) begin
			data_ready_n <= 1'b0;
		end else if (fall || start_evt || init_busy) begin
			data_ready_n <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			filter_reset <= 1'b0;
		end else begin
			filter_reset <= start_evt | cfg_new | soft_rst;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			init_cnt <= 5'd0;
			modcnt <= 5'd0;
			pd_cnt <= 10'd0;
			powered_down <= 1'b0;
		end else begin
			if (soft_rst) begin
				init_cnt <= INIT_CYC;
			end else if (init_cnt != 5'd0) begin
				init_cnt <= init_cnt - 5'd1;
			end
			modcnt <= (pwdn_s || mod_tick) ? 5'd0 : modcnt + 5'd1;
			if (pwdn_s) begin
				pd_cnt <= 10'd0;
			end else if (mod_tick && pd_cnt != 10'(PD_MODS)) begin
				pd_cnt <= pd_cnt + 10'd1;
			end
			powered_down <= ~pwdn_s & (pd_cnt == 10'(PD_MODS));
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence last_rise_s;
		rise && rd_act && fcnt == LAST_BIT;
	endsequence

	sequence rst_byte_s;
		byte_end && state == ashp_pkg::st_cmd && opcode == `ASHP_OP_RESET;
	endsequence

	dout_float_a: assert property (cs_s |-> !dout_oe ##1 (!dout && fcnt == 0))
		else $error("data-out driven while deselected");
	ready_low_a: assert property (load |=> !data_ready_n)
		else $error("data-ready not low after completion");
	deselect_clr_a: assert property (!sel |=> state == ashp_pkg::st_cmd && bcnt == 0)
		else $error("interface not reset by deselect");
	din_sample_a: assert property (bit_in |=> shreg[0] == $past(din_s))
		else $error("data-in not sampled on falling edge");
	msb_first_a: assert property (rise && rd_act && fcnt == 0 |=> dout == $past(frame[47]))
		else $error("first bit is not the MSB");
	ready_high_a: assert property (fall && !load |=> data_ready_n)
		else $error("data-ready not raised by falling edge");
	status_word_a: assert property (load |=> frame[47:44] == `ASHP_STAT_SYNC && frame[36:32] == 5'h00)
		else $error("status word pattern wrong");
	chan_zero_a: assert property (load && chan_powerdown[0] |=> frame[31:16] == 0)
		else $error("powered-down channel not zero");
	frame_repeat_a: assert property (last_rise_s |=> fcnt == 0)
		else $error("frame does not wrap");
	frame_hold_a: assert property (busy |=> $stable(frame))
		else $error("frame changed mid-read");
	pin_dir_a: assert property (init_busy |=> gpio_oe == 2'b00 && gpio_out == 2'b00)
		else $error("pins not back to inputs after reset");
	reset_cmd_a: assert property (rst_byte_s |=> init_cnt == INIT_CYC ##17 init_cnt == 1)
		else $error("reset command timing wrong");
	cfg_filter_a: assert property (cfg_new |=> filter_reset)
		else $error("config write did not reset filter");
	start_ready_a: assert property (start_evt && !load |=> data_ready_n && running)
		else $error("start did not raise data-ready");
	one_shot_a: assert property (accept && primary_config_reg[7] && !start_evt |=> !running)
		else $error("single-shot did not stop");
endmodule

// *** bench/ashp_host_model.sv ***
// Host-side serial master model for the converter port
`timescale 1ns/1ps
module ashp_host_model (
	// Serial pins toward the port
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	// Half of the 160 ns link period
	localparam time HALF = 80ns;
	logic last_rx = 1'b0;
	// Clock parks low between frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// One bit, period far inside both limits
	task automatic bit_x(input logic b, output logic r);
		sclk = 1'b1;
		din = b;
		#HALF;
		sclk = 1'b0;
		#HALF;
		// Floating line reads back as the inverse of the last bit
		r = dout_oe ? dout : ~last_rx;
		last_rx = r;
	endtask
	// Always a whole byte of clocks
	task automatic send_byte(input logic [7:0] b, output logic [7:0] r);
		logic x;
		for (int i = 7; i >= 0; i--) begin
			bit_x(b[i], x);
			r[i] = x;
		end
	endtask
	task automatic read_frame(output logic [47:0] r);
		logic x;
		for (int i = 47; i >= 0; i--) begin
			bit_x(1'b0, x);
			r[i] = x;
		end
	endtask
	task automatic sel();
		cs_n = 1'b0;
		#HALF;
	endtask
	// Well over four master clocks before deselect
	task automatic desel();
		din = 1'b0;
		#200ns;
		cs_n = 1'b1;
		#400ns;
	endtask
endmodule

// *** bench/tb_ashp_port.sv ***
// Self-checking bench for the converter serial host port
`timescale 1ns/1ps
`include "ashp_map.svh"
module tb_ashp_port;
	localparam int PD = 4;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic start_pin = 1'b0;
	logic powerdown_reset_n = 1'b1;
	logic [1:0] pin_drv = 2'b10;
	logic sample_valid = 1'b0;
	logic [31:0] sample_data = 32'h0000_0000;
	logic [4:0] lead_off_flags = 5'h15;
	logic [1:0] chan_powerdown = 2'b00;
	logic cs_n, sclk, din, dout, dout_oe, data_ready_n, sample_ready;
	logic conv_run, filter_reset, powered_down, continuous_read_mode;
	logic [1:0] gpio_out, gpio_oe, pin_level_bits;
	wire logic [1:0] gpio_in;
	int fr_cnt = 0;
	int error_cnt = 0;
	int total_checks = 0;
	// Pin wire seen by the port mixes its own drive with the board's
	assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & pin_drv);
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (filter_reset === 1'b1)
			fr_cnt <= fr_cnt + 1;
	end
	ashp_port #(.FIFO_DEPTH(4), .PD_MODS(PD)) u_dut (
		.core_clk(core_clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout), .dout_oe(dout_oe), .data_ready_n(data_ready_n),
		.start_pin(start_pin), .powerdown_reset_n(powerdown_reset_n),
		.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.sample_valid(sample_valid), .sample_ready(sample_ready),
		.sample_data(sample_data), .lead_off_flags(lead_off_flags),
		.chan_powerdown(chan_powerdown), .conv_run(conv_run),
		.filter_reset(filter_reset), .powered_down(powered_down),
		.continuous_read_mode(continuous_read_mode), .pin_level_bits(pin_level_bits)
	);
	ashp_host_model u_host (
		.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe)
	);
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: return data_ready_n;
			1: return conv_run;
			default: return sample_valid & sample_ready & conv_run;
		endcase
	endfunction
	// Bounded wait, sampled on the quiet edge
	task automatic wait_on(input int w, input logic v, input int lim);
		int n;
		n = 0;
		@(negedge core_clk);
		while (sig(w) !== v) begin
			@(negedge core_clk);
			n++;
			if (n > lim) begin
				error_cnt++;
				print_verdict();
			end
		end
	endtask
	task automatic offer(input logic [31:0] d);
		@(posedge core_clk);
		sample_valid <= 1'b1;
		sample_data <= d;
		wait_on(2, 1'b1, 400);
		@(posedge core_clk);
		sample_valid <= 1'b0;
	endtask
	task automatic cmd(input logic [7:0] op);
		logic [7:0] r;
		@(negedge core_clk);
		u_host.sel();
		u_host.send_byte(op, r);
		u_host.desel();
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		logic [7:0] r;
		@(negedge core_clk);
		u_host.sel();
		u_host.send_byte({`ASHP_OP_REGWR_HI, a}, r);
		u_host.send_byte(8'h00, r);
		u_host.send_byte(v, r);
		u_host.desel();
	endtask
	function automatic logic [47:0] frame(input logic [31:0] d, input logic [1:0] pd);
		return {`ASHP_STAT_SYNC, lead_off_flags, pin_drv, 5'b0_0000,
			pd[0] ? 16'h0000 : d[31:16], pd[1] ? 16'h0000 : d[15:0]};
	endfunction
	initial begin
		#500us;
		error_cnt++;
		print_verdict();
	end
	initial begin
		logic [47:0] fr;
		logic [7:0] b;
		int n0;
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk(gpio_oe, 2'b00);
		chk(dout_oe, 1'b0);
		chk(continuous_read_mode, 1'b1);
		sample_valid <= 1'b1;
		sample_data <= 32'h8001_7FFE;
		repeat (40) @(posedge core_clk);
		chk(data_ready_n, 1'b1);
		start_pin <= 1'b1;
		wait_on(2, 1'b1, 100);
		@(posedge core_clk);
		sample_valid <= 1'b0;
		wait_on(0, 1'b0, 100);
		chk(data_ready_n, 1'b0);
		u_host.sel();
		u_host.read_frame(fr);
		chk(fr, frame(32'h8001_7FFE, 2'b00));
		chk(data_ready_n, 1'b1);
		u_host.send_byte(8'h00, b);
		chk(b, frame(32'h8001_7FFE, 2'b00) >> 40);
		u_host.desel();
		chk(dout_oe, 1'b0);
		@(posedge core_clk);
		chan_powerdown <= 2'b01;
		offer(32'h1234_ABCD);
		wait_on(0, 1'b0, 100);
		u_host.sel();
		u_host.read_frame(fr);
		u_host.desel();
		chk(fr, frame(32'h1234_ABCD, 2'b01));
		// Aborted opcode must not spoil the next one
		u_host.sel();
		repeat (3) u_host.bit_x(1'b1, b[0]);
		u_host.desel();
		cmd({`ASHP_OP7_SDATAC, 1'b0});
		chk(continuous_read_mode, 1'b0);
		@(posedge core_clk);
		start_pin <= 1'b0;
		chan_powerdown <= 2'b00;
		// Start by command keeps the pin low
		cmd({`ASHP_OP7_START, 1'b0});
		wait_on(1, 1'b1, 200);
		offer(32'h5A5A_0F0F);
		wait_on(0, 1'b0, 200);
		u_host.sel();
		u_host.send_byte({`ASHP_OP7_RDATA, 1'b0}, b);
		fork
			u_host.read_frame(fr);
			begin
				repeat (100) @(posedge core_clk);
				offer(32'h0BAD_F00D);
			end
		join
		u_host.desel();
		chk(fr, frame(32'h5A5A_0F0F, 2'b00));
		cmd({`ASHP_OP7_STOP, 1'b0});
		wait_on(1, 1'b0, 300);
		chk(conv_run, 1'b0);
		n0 = fr_cnt;
		wr_reg(`ASHP_ADDR_CFG, 8'h82);
		chk(fr_cnt != n0, 1'b1);
		@(posedge core_clk);
		start_pin <= 1'b1;
		offer(32'h0001_FFFF);
		wait_on(0, 1'b0, 200);
		repeat (10) @(posedge core_clk);
		chk(conv_run, 1'b0);
		chk(data_ready_n, 1'b0);
		wr_reg(`ASHP_ADDR_PIN, 8'h01);
		chk({gpio_oe, gpio_out, pin_level_bits}, 6'b11_0101);
		wr_reg(`ASHP_ADDR_PIN, 8'h0E);
		chk({gpio_oe, gpio_out, pin_level_bits}, {4'b00_01, pin_drv});
		wr_reg(`ASHP_ADDR_PIN, 8'h01);
		cmd(`ASHP_OP_RESET);
		chk({gpio_oe, continuous_read_mode}, 3'b001);
		wr_reg(`ASHP_ADDR_PIN, 8'h01);
		@(posedge core_clk);
		powerdown_reset_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk(powered_down, 1'b0);
		repeat (PD * 4 + 10) @(posedge core_clk);
		chk(powered_down, 1'b1);
		powerdown_reset_n <= 1'b1;
		repeat (40) @(posedge core_clk);
		chk(gpio_oe, 2'b00);
		chk(powered_down, 1'b0);
		print_verdict();
	end
endmodule
